// File: rtl/aso_cfg.svh
`ifndef ASO_CFG_SVH
`define ASO_CFG_SVH
// word and raw sample widths, code span
`define ASO_WORD_W 12
`define ASO_RAW_W 14
`define ASO_CODE_MAX 14'h0FFF
`define ASO_MSB_MASK 12'h800
`define ASO_PIPE_DEPTH 3
// four-level clock/format strap codes from the strap comparator
`define ASO_CF_VA 2'h3
`define ASO_CF_TWO_THIRDS 2'h2
`define ASO_CF_ONE_THIRD 2'h1
`define ASO_CF_GND 2'h0
// three-level power strap codes
`define ASO_PS_VA 2'h2
`define ASO_PS_HALF 2'h1
`define ASO_PS_GND 2'h0
// wake-up times and their cycle counts at core_clk
`define ASO_CLK_MHZ 25
`define ASO_SLEEP_WAKE_NS 400
`define ASO_DOWN_WAKE_NS 2000
`define ASO_SLEEP_WAKE_CYC ((`ASO_SLEEP_WAKE_NS * `ASO_CLK_MHZ + 999) / 1000)
`define ASO_DOWN_WAKE_CYC ((`ASO_DOWN_WAKE_NS * `ASO_CLK_MHZ + 999) / 1000)
// register word offsets, decoded from byte address bits 7:2
`define ASO_REG_CTRL 6'h00
`define ASO_REG_MODE 6'h01
`define ASO_REG_LAST 6'h02
`define ASO_REG_IRQ_STATUS 6'h03
`define ASO_REG_IRQ_CLEAR 6'h04
`define ASO_REG_IRQ_ENABLE 6'h05
`define ASO_REG_COUNT 6'h06
// reset values and interrupt bits
`define ASO_CTRL_RESET 1'h1
`define ASO_IRQ_EN_RESET 4'h0
`define ASO_IRQ_RANGE 0
`define ASO_IRQ_STRAP 1
`define ASO_IRQ_NEGCLK 2
`define ASO_IRQ_WAKE 3
`define ASO_RESP_OKAY 2'h0
`define ASO_RESP_SLVERR 2'h2
`endif

// File: rtl/aso_pkg.sv
package aso_pkg;
  `include "aso_cfg.svh"

  // power state machine, one-hot
  typedef enum logic [3:0] {
    ASO_RUN = 4'h1,
    ASO_SLEEP = 4'h2,
    ASO_DOWN = 4'h4,
    ASO_WAKE = 4'h8
  } aso_pwr_t;

  // one output code with its over-range flag
  typedef struct packed {
    logic overRange;
    logic [`ASO_WORD_W-1:0] word;
  } aso_code_t;

  // decoded strap settings
  typedef struct packed {
    logic diffClock;
    logic twosComp;
  } aso_mode_t;
endpackage

// File: rtl/aso_pin_sync.sv
`timescale 1ns/10ps
`include "aso_cfg.svh"
module aso_pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // asynchronous pins and their settled level
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinLevel
);
  import aso_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } aso_sync_t;

  aso_sync_t st;
  aso_sync_t next_st;

  // three stages; a bit counts only once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pinLevel = st.level;
endmodule

// File: rtl/aso_code_format.sv
`timescale 1ns/10ps
`include "aso_cfg.svh"
module aso_code_format (
  // quantiser value and selected format
  input wire logic signed [`ASO_RAW_W-1:0] rawSample,
  input wire logic twosComp,
  // saturated, formatted code
  output aso_pkg::aso_code_t fmtCode
);
  import aso_pkg::*;

  // clamp to the code span, then flip the msb for two's complement
  always_comb begin
    fmtCode = '0;
    if (rawSample < 0) begin
      fmtCode.overRange = 1'b1;
      fmtCode.word = '0;
    end else if (rawSample > $signed(`ASO_CODE_MAX)) begin
      fmtCode.overRange = 1'b1;
      fmtCode.word = 12'(`ASO_CODE_MAX);
    end else begin
      fmtCode.word = rawSample[`ASO_WORD_W-1:0];
    end
    if (twosComp) begin
      fmtCode.word = fmtCode.word ^ `ASO_MSB_MASK;
    end
  end
endmodule

// File: rtl/aso_sample_output_ctrl.sv
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "aso_cfg.svh"
module aso_sample_output_ctrl #(
  parameter int PIPE_DEPTH = `ASO_PIPE_DEPTH,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // sampling clock pins
  input wire logic clkPosPin,
  input wire logic clkNegPin,
  // strap level codes from the strap comparators
  input wire logic [1:0] clockFormatStrap,
  input wire logic [1:0] powerStateStrap,
  // quantiser result, outside 0..4095 when the input is out of range
  input wire logic signed [`ASO_RAW_W-1:0] rawSample,
  // parallel output bus
  output logic [`ASO_WORD_W-1:0] sampleWordOut,
  output logic overRangeFlag,
  output logic outputWordStrobe,
  // interrupt
  output logic irq,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import aso_pkg::*;

  localparam logic [7:0] SLEEP_WAKE = 8'(`ASO_SLEEP_WAKE_CYC);
  localparam logic [7:0] DOWN_WAKE = 8'(`ASO_DOWN_WAKE_CYC);

  typedef struct packed {
    aso_pwr_t pwr;
    logic [7:0] wakeCnt;
    logic clkPrev;
    logic [PIPE_DEPTH-1:0] pipeValid;
    aso_code_t [PIPE_DEPTH-1:0] pipe;
    aso_code_t out;
    logic outValid;
    logic strobe;
    logic run;
    logic [3:0] irqStatus;
    logic [3:0] irqEnable;
    logic irqOut;
    logic [3:0] strapPrev;
    logic [31:0] sampleCount;
    logic awready;
    logic wready;
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0] wByte;
    logic wLane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } aso_state_t;

  aso_state_t st;
  aso_state_t next_st;
  logic [1:0] clkSync;
  logic [1:0] clkStrap;
  logic [1:0] pwrStrap;
  aso_mode_t mode;
  aso_code_t fmtCode;
  logic clkLevel;
  logic fallEvt;
  logic convActive;

  // pins from outside the core_clk domain
  aso_pin_sync #(.WIDTH(2)) u_clk_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pinIn({clkNegPin, clkPosPin}),
    .pinLevel(clkSync)
  );

  aso_pin_sync #(.WIDTH(4)) u_strap_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pinIn({clockFormatStrap, powerStateStrap}),
    .pinLevel({clkStrap, pwrStrap})
  );

  // strap decode and sampling clock recovery
  always_comb begin
    mode.diffClock = (clkStrap == `ASO_CF_VA) || (clkStrap == `ASO_CF_TWO_THIRDS);
    mode.twosComp = (clkStrap == `ASO_CF_VA) || (clkStrap == `ASO_CF_ONE_THIRD);
    // in differential mode the level is high only with the positive pin high and the negative pin low
    clkLevel = mode.diffClock ? (clkSync[0] & ~clkSync[1]) : clkSync[0];
    fallEvt = st.clkPrev & ~clkLevel;
    convActive = (st.pwr == ASO_RUN) && st.run;
  end

  aso_code_format u_format (
    .rawSample(rawSample),
    .twosComp(mode.twosComp),
    .fmtCode(fmtCode)
  );

  // next state of the whole block
  always_comb begin
    logic [3:0] events;
    logic [3:0] clearMask;
    logic [5:0] rIdx;
    logic [5:0] wIdx;
    events = '0;
    clearMask = '0;
    rIdx = s_axi_araddr[7:2];
    wIdx = st.awAddr[7:2];
    next_st = st;
    next_st.clkPrev = clkLevel;
    next_st.strapPrev = {clkStrap, pwrStrap};

    // power state machine
    case (st.pwr)
      ASO_RUN: begin
        if (pwrStrap == `ASO_PS_VA) begin
          next_st.pwr = ASO_DOWN;
        end else if (pwrStrap == `ASO_PS_HALF) begin
          next_st.pwr = ASO_SLEEP;
        end
      end
      ASO_SLEEP, ASO_DOWN: begin
        // sleep recovers faster than power-down
        if (pwrStrap == `ASO_PS_GND) begin
          next_st.pwr = ASO_WAKE;
          next_st.wakeCnt = (st.pwr == ASO_SLEEP) ? SLEEP_WAKE : DOWN_WAKE;
        end else if (pwrStrap == `ASO_PS_VA) begin
          next_st.pwr = ASO_DOWN;
        end else begin
          next_st.pwr = ASO_SLEEP;
        end
      end
      ASO_WAKE: begin
        if (pwrStrap == `ASO_PS_VA) begin
          next_st.pwr = ASO_DOWN;
        end else if (pwrStrap == `ASO_PS_HALF) begin
          next_st.pwr = ASO_SLEEP;
        end else if (st.wakeCnt <= 8'h01) begin
          next_st.pwr = ASO_RUN;
          next_st.wakeCnt = '0;
          events[`ASO_IRQ_WAKE] = 1'b1;
        end else begin
          next_st.wakeCnt = st.wakeCnt - 8'h01;
        end
      end
      default: begin
        next_st.pwr = ASO_RUN;
      end
    endcase

    // conversion pipeline, advanced once per sampling clock
    if (!convActive) begin
      // a stopped converter flushes, so a restart never repeats an old word
      next_st.pipeValid = '0;
      next_st.outValid = 1'b0;
      next_st.strobe = 1'b0;
    end else begin
      if (fallEvt) begin
        next_st.pipe[0] = fmtCode;
        next_st.pipeValid[0] = 1'b1;
        for (int i = 1; i < PIPE_DEPTH; i++) begin
          next_st.pipe[i] = st.pipe[i-1];
          next_st.pipeValid[i] = st.pipeValid[i-1];
        end
        next_st.sampleCount = st.sampleCount + 32'h1;
        if (st.pipeValid[PIPE_DEPTH-1]) begin
          next_st.out = st.pipe[PIPE_DEPTH-1];
          next_st.outValid = 1'b1;
          events[`ASO_IRQ_RANGE] = st.pipe[PIPE_DEPTH-1].overRange;
        end
      end
      // strobe low while the word changes, high half a period later;
      // held low until a fresh word stands, else the first rise repeats a stale one
      next_st.strobe = clkLevel & st.outValid;
    end

    // fault seen: negative clock pin high in single-ended mode
    events[`ASO_IRQ_NEGCLK] = !mode.diffClock && clkSync[1];
    events[`ASO_IRQ_STRAP] = ({clkStrap, pwrStrap} != st.strapPrev);

    // axi write address and data, in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.awready = 1'b0;
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.wready = 1'b0;
      next_st.wHeld = 1'b1;
      next_st.wByte = s_axi_wdata[7:0];
      next_st.wLane = s_axi_wstrb[0];
    end
    if (st.awHeld && st.wHeld && !st.bvalid) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `ASO_RESP_OKAY;
      case (wIdx)
        `ASO_REG_CTRL: begin
          if (st.wLane) begin
            next_st.run = st.wByte[0];
          end
        end
        `ASO_REG_IRQ_CLEAR: begin
          if (st.wLane) begin
            clearMask = st.wByte[3:0];
          end
        end
        `ASO_REG_IRQ_ENABLE: begin
          if (st.wLane) begin
            next_st.irqEnable = st.wByte[3:0];
          end
        end
        `ASO_REG_MODE, `ASO_REG_LAST, `ASO_REG_IRQ_STATUS, `ASO_REG_COUNT: begin
          next_st.bresp = `ASO_RESP_OKAY; // read-only, write ignored
        end
        default: begin
          next_st.bresp = `ASO_RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // axi read, one at a time
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = `ASO_RESP_OKAY;
      next_st.rdata = '0;
      case (rIdx)
        `ASO_REG_CTRL: next_st.rdata[0] = st.run;
        `ASO_REG_MODE: next_st.rdata[11:0] = {st.pwr, clkStrap, pwrStrap, mode, 2'h0};
        `ASO_REG_LAST: next_st.rdata[12:0] = st.out;
        `ASO_REG_IRQ_STATUS: next_st.rdata[3:0] = st.irqStatus;
        `ASO_REG_IRQ_CLEAR: next_st.rdata = '0;
        `ASO_REG_IRQ_ENABLE: next_st.rdata[3:0] = st.irqEnable;
        `ASO_REG_COUNT: next_st.rdata = st.sampleCount;
        default: next_st.rresp = `ASO_RESP_SLVERR;
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // sticky status: a new event wins over a clear in the same cycle
    next_st.irqStatus = (st.irqStatus & ~clearMask) | events;
    next_st.irqOut = |(next_st.irqStatus & next_st.irqEnable);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
      st.pwr <= ASO_RUN;
      st.run <= `ASO_CTRL_RESET;
      st.irqEnable <= `ASO_IRQ_EN_RESET;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign sampleWordOut = st.out.word;
  assign overRangeFlag = st.out.overRange;
  assign outputWordStrobe = st.strobe;
  assign irq = st.irqOut;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // helper: word updates since the last strobe rise
  logic [1:0] updSinceRise;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      updSinceRise <= '0;
    end else if (!convActive || (!st.strobe && next_st.strobe)) begin
      updSinceRise <= '0;
    end else if (next_st.out != st.out && updSinceRise != 2'h3) begin
      updSinceRise <= updSinceRise + 2'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic irqStatus_negclk;
  assign irqStatus_negclk = st.irqStatus[`ASO_IRQ_NEGCLK];
  property p_diff_decode;
    clkStrap == `ASO_CF_GND && clkSync[1] |=> irqStatus_negclk;
  endproperty
  a_diff_decode: assert property (p_diff_decode) else $error("neg clock fault not flagged");

  property p_offset_fmt;
    (clkStrap == `ASO_CF_GND || clkStrap == `ASO_CF_TWO_THIRDS) && rawSample >= 0
      && rawSample <= $signed(`ASO_CODE_MAX) |-> fmtCode.word == rawSample[11:0];
  endproperty
  a_offset_fmt: assert property (p_offset_fmt) else $error("offset binary code wrong");

  property p_twos_fmt;
    (clkStrap == `ASO_CF_VA || clkStrap == `ASO_CF_ONE_THIRD) && !fmtCode.overRange
      |-> fmtCode.word == {~rawSample[11], rawSample[10:0]};
  endproperty
  a_twos_fmt: assert property (p_twos_fmt) else $error("twos complement code wrong");

  property p_pd_enter;
    st.pwr == ASO_RUN && pwrStrap == `ASO_PS_VA |=> st.pwr == ASO_DOWN;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

  property p_quiet_low;
    st.pwr inside {ASO_DOWN, ASO_SLEEP} |=> !outputWordStrobe && $stable(sampleWordOut);
  endproperty
  a_quiet_low: assert property (p_quiet_low) else $error("output active in low power");

  property p_sample_count;
    convActive && fallEvt |=> st.sampleCount == $past(st.sampleCount) + 32'h1;
  endproperty
  a_sample_count: assert property (p_sample_count) else $error("falling edge not sampled");

  property p_saturate;
    rawSample > $signed(`ASO_CODE_MAX) |-> fmtCode.overRange
      && fmtCode.word == (mode.twosComp ? 12'h7FF : 12'hFFF);
  endproperty
  a_saturate: assert property (p_saturate) else $error("over-range code wrong");

  property p_under;
    rawSample < 0 |-> fmtCode.overRange && fmtCode.word == (mode.twosComp ? 12'h800 : 12'h000);
  endproperty
  a_under: assert property (p_under) else $error("under-range code wrong");

  property p_strobe_rise;
    convActive && !st.clkPrev && clkLevel && st.outValid
      |=> outputWordStrobe;
  endproperty
  a_strobe_rise: assert property (p_strobe_rise) else $error("strobe missed clock rise");

  property p_one_word;
    updSinceRise <= 2'h1;
  endproperty
  a_one_word: assert property (p_one_word) else $error("two words in one strobe period");

  property p_latency;
    convActive && fallEvt && st.pipeValid[PIPE_DEPTH-1]
      |=> {overRangeFlag, sampleWordOut} == $past(st.pipe[PIPE_DEPTH-1]);
  endproperty
  a_latency: assert property (p_latency) else $error("pipeline output wrong");

  c_overrange: cover property (overRangeFlag && $rose(outputWordStrobe));
  c_wake: cover property (st.pwr == ASO_WAKE ##1 st.pwr == ASO_RUN);
  c_twos_word: cover property (mode.twosComp && $rose(outputWordStrobe));
endmodule

// File: tb/aso_capture_model.sv
`timescale 1ns/10ps
`include "aso_cfg.svh"
module aso_capture_model (
  // receiver side of the parallel output bus
  input wire logic outputWordStrobe,
  input wire logic [`ASO_WORD_W-1:0] sampleWordOut,
  input wire logic overRangeFlag
);
  import aso_pkg::*;
  aso_code_t capQ[$];
  // register word and flag on the strobe rising edge; the falling edge
  // would catch a word that may be changing
  always @(posedge outputWordStrobe) begin
    capQ.push_back({overRangeFlag, sampleWordOut});
  end
endmodule

// File: tb/test_adc_sample_output_mode_ctrl.sv
`timescale 1ns/10ps
`include "aso_cfg.svh"
module test_adc_sample_output_mode_ctrl;
  import aso_pkg::*;
  localparam logic [7:0] adrCtrl = {`ASO_REG_CTRL, 2'h0};
  localparam logic [7:0] adrMode = {`ASO_REG_MODE, 2'h0};
  localparam logic [7:0] adrLast = {`ASO_REG_LAST, 2'h0};
  localparam logic [7:0] adrStat = {`ASO_REG_IRQ_STATUS, 2'h0};
  localparam logic [7:0] adrClr = {`ASO_REG_IRQ_CLEAR, 2'h0};
  localparam logic [7:0] adrEn = {`ASO_REG_IRQ_ENABLE, 2'h0};
  localparam logic [1:0] okay = `ASO_RESP_OKAY;
  localparam logic [1:0] slvErr = `ASO_RESP_SLVERR;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clkPosPin = 1'b0;
  logic clkNegPin = 1'b0;
  logic diffMode = 1'b0;
  logic [1:0] clockFormatStrap = 2'h0;
  logic [1:0] powerStateStrap = 2'h0;
  logic signed [13:0] rawSample = 14'sh0000;
  logic [11:0] sampleWordOut;
  logic overRangeFlag, outputWordStrobe, irq;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int failures = 0;
  int testsRun = 0;
  int cycles = 0;
  // in range, both ends, under and over range, mid codes
  logic signed [13:0] pat [8] = '{14'sh0000, 14'sh0001, 14'sh0800, 14'sh0FFF,
    -14'sh0005, 14'sh1388, 14'sh07FF, 14'sh0064};

  aso_sample_output_ctrl #(.PIPE_DEPTH(`ASO_PIPE_DEPTH), .ADDR_W(8)) i_dut (
    .core_clk, .reset, .clkPosPin, .clkNegPin, .clockFormatStrap, .powerStateStrap,
    .rawSample, .sampleWordOut, .overRangeFlag, .outputWordStrobe, .irq,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  aso_capture_model i_rx (.outputWordStrobe, .sampleWordOut, .overRangeFlag);

  // 25 MHz system clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // offset binary with saturation, msb flipped for two's complement
  function automatic aso_code_t expect_code(input logic signed [13:0] r, input logic tc);
    aso_code_t c;
    c.overRange = (r < 14'sh0000) || (r > 14'sh0FFF);
    c.word = (r < 14'sh0000) ? 12'h000 : (r > 14'sh0FFF) ? 12'hFFF : r[11:0];
    if (tc) c.word = c.word ^ `ASO_MSB_MASK;
    return c;
  endfunction

  // the edge first, so no handshake signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        check(s_axi_bresp, er, "bresp");
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        check(s_axi_rdata & m, ed, "rdata");
        check(s_axi_rresp, er, "rresp");
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // one sampling period of 16 system cycles, sample value set while high
  task automatic sample_period(input logic signed [13:0] v);
    clkPosPin <= 1'b1;
    clkNegPin <= 1'b0;
    rawSample <= v;
    repeat (8) @(posedge core_clk);
    clkPosPin <= 1'b0;
    clkNegPin <= diffMode;
    repeat (8) @(posedge core_clk);
  endtask

  // the pattern plus fillers; the last eight captures must be the pattern
  task automatic run_seq(input logic tc, input int expCount);
    int base;
    i_rx.capQ.delete();
    foreach (pat[i]) sample_period(pat[i]);
    repeat (`ASO_PIPE_DEPTH + 1) sample_period(14'sh0000);
    if (expCount >= 0) check(i_rx.capQ.size(), expCount, "word count");
    base = i_rx.capQ.size() - 8;
    check(base >= 0, 1'b1, "too few words");
    for (int i = 0; i < 8 && base >= 0; i++) begin
      check(i_rx.capQ[base + i], expect_code(pat[i], tc), "code");
    end
    rd(adrLast, 32'h1FFF, {19'h0, expect_code(14'sh0000, tc)}, okay);
  endtask

  // no word may come out while halted
  task automatic idle_none();
    i_rx.capQ.delete();
    repeat (6) sample_period(pat[2]);
    check(i_rx.capQ.size(), 0, "words while halted");
  endtask

  // single-ended mode with the negative pin left high must raise the fault bit
  task automatic neg_fault();
    clockFormatStrap <= `ASO_CF_GND;
    diffMode <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(adrStat, 32'h4, 32'h4, okay);
    clkNegPin <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(adrClr, 32'h4, okay);
    rd(adrStat, 32'h4, 32'h0, okay);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    // reset values, unmapped and read-only places
    rd(adrCtrl, 32'hFFFFFFFF, 32'h1, okay);
    rd(adrEn, 32'hFFFFFFFF, 32'h0, okay);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0, slvErr);
    wr(8'h1C, 32'h1, slvErr);
    wr(adrMode, 32'hFFF, okay);
    rd(adrClr, 32'hFFFFFFFF, 32'h0, okay);
    // every clock/format strap level
    for (int s = 0; s < 4; s++) begin
      clockFormatStrap <= s[1:0];
      diffMode <= s[1];
      clkNegPin <= s[1];
      repeat (8) @(posedge core_clk);
      rd(adrMode, 32'hFFF, {20'h0, 4'h1, s[1:0], 2'h0, s[1], s[0], 2'h0}, okay);
      run_seq(s[0], -1);
    end
    // interrupt raised, masked, cleared
    rd(adrStat, 32'h3, 32'h3, okay);
    wr(adrEn, 32'h1, okay);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b1, "irq enabled");
    wr(adrEn, 32'h0, okay);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0, "irq masked");
    wr(adrClr, 32'hF, okay);
    rd(adrStat, 32'hF, 32'h0, okay);
    wr(adrEn, 32'hF, okay);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0, "irq after clear");
    // sleep, then a fresh pipeline, then continuous running
    powerStateStrap <= `ASO_PS_HALF;
    repeat (10) @(posedge core_clk);
    rd(adrMode, 32'hF30, 32'h210, okay);
    idle_none();
    powerStateStrap <= `ASO_PS_GND;
    repeat (24) @(posedge core_clk);
    rd(adrMode, 32'hF00, 32'h100, okay);
    rd(adrStat, 32'h8, 32'h8, okay);
    check(irq, 1'b1, "wake irq");
    run_seq(1'b1, 8);
    run_seq(1'b1, 12);
    // power-down recovers later than sleep
    powerStateStrap <= `ASO_PS_VA;
    repeat (10) @(posedge core_clk);
    rd(adrMode, 32'hF30, 32'h420, okay);
    idle_none();
    powerStateStrap <= `ASO_PS_GND;
    repeat (24) @(posedge core_clk);
    rd(adrMode, 32'hF00, 32'h800, okay);
    repeat (50) @(posedge core_clk);
    rd(adrMode, 32'hF00, 32'h100, okay);
    // software halt through the run bit
    wr(adrCtrl, 32'h0, okay);
    idle_none();
    wr(adrCtrl, 32'h1, okay);
    run_seq(1'b1, 8);
    neg_fault();
    report_and_stop();
  end
endmodule
